// ==== pbmc_pkg.sv ====
package pbmc_pkg;
  // Register map
  localparam logic [4:0]  BASIC_MODE_CONTROL_OFFSET = 5'h00;
  localparam logic [15:0] BASIC_MODE_CONTROL_RESET  = 16'h3100;
  // Field positions
  localparam int SOFT_RESET_BIT   = 15;
  localparam int LOOPBACK_BIT     = 14;
  localparam int SPEED_BIT        = 13;
  localparam int AUTONEG_EN_BIT   = 12;
  localparam int POWER_DOWN_BIT   = 11;
  localparam int ISOLATE_BIT      = 10;
  localparam int AUTONEG_RST_BIT  = 9;
  localparam int DUPLEX_BIT       = 8;
  localparam int COL_TEST_BIT     = 7;
  // Writable bits; reserved 6..0 never stored
  localparam logic [15:0] WRITE_MASK = 16'hff80;
  // Timing: bit times at 10 Mbps (100 ns) and clock period
  localparam int BIT_TIME_NS      = 100;
  localparam int CLOCK_PERIOD_NS  = 50;
  localparam int COL_ASSERT_BITS  = 512;
  localparam int COL_RELEASE_BITS = 4;
  // Longest times round down; assert COL after one cycle to be well inside
  localparam int COL_ASSERT_CYCLES  = 1;
  localparam int COL_RELEASE_MAX    = (COL_RELEASE_BITS * BIT_TIME_NS) / CLOCK_PERIOD_NS;
  // Soft reset duration in cycles
  localparam logic [3:0] SOFT_RESET_CYCLES = 4'h8;
endpackage

// ==== pbmc_basic_control.sv ====
`timescale 1ns/1ns
// Behaviour
// - Loopback bit set returns transmit data to receive outputs internally.
// - Without auto-negotiation, bit 13 picks speed; 1 is 100 Mbps, default 1.
// - Auto-negotiation enabled ignores speed and duplex bits; disabled uses them.
// - Power-down bit ORed with low pin; pin assertion sets the bit.
// - Powered down keeps only register access; other functions suspended.
// - Isolate disconnects port from MAC data, management stays working.
// - Isolate in master mode stops driving the 50 MHz reference clock.
// - Restart write ignored while auto-negotiation is disabled.
// - Restart bit reads one until negotiation restarts, then clears itself.
// - Writing zero to restart never disturbs a running negotiation.
// - Without auto-negotiation, bit 8 picks duplex; 1 is full, default 1.
// - Collision test asserts COL within 512 bit times of TX_EN.
// - Collision test drops COL within 4 bit times after TX_EN falls.
// - Bit 15 resets standard registers, then clears itself when done.
// - Control register holds 0x3100 after reset.
module pbmc_basic_control
  import pbmc_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        reset_n,
  // Management register port
  input  wire logic        reg_write,
  input  wire logic [4:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  output logic [15:0]      reg_rdata,
  // Pin and auto-negotiation engine
  input  wire logic        irq_powerdown_pin_n,
  output logic             autoneg_restart,
  input  wire logic        autoneg_started,
  output logic             autoneg_enable,
  output logic             speed_100,
  input  wire logic        speed_100_negotiated,
  output logic             full_duplex,
  input  wire logic        full_duplex_negotiated,
  output logic             power_down,
  output logic             soft_reset_busy,
  // RMII side
  input  wire logic        rmii_master_mode,
  input  wire logic        ref_clock_in,
  output logic             ref_clock_out,
  output logic             ref_clock_oe_n,
  input  wire logic        mac_tx_en,
  input  wire logic [1:0]  mac_txd,
  output logic             mac_crs_dv,
  output logic [1:0]       mac_rxd,
  output logic             mac_col,
  output logic             line_tx_en,
  output logic [1:0]       line_txd,
  input  wire logic        line_crs_dv,
  input  wire logic [1:0]  line_rxd
);

  typedef enum logic [1:0] {PBMC_IDLE, PBMC_PENDING} pbmc_restart_type;

  logic             loopback;
  logic             speed_sel;
  logic             autoneg_en_bit;
  logic             power_down_bit;
  logic             isolate;
  logic             duplex_sel;
  logic             col_test;
  logic [3:0]       soft_reset_count;
  pbmc_restart_type restart_state;
  logic             active;
  logic             hit;
  logic [15:0]      control_word;

  assign hit    = reg_write && (reg_addr == BASIC_MODE_CONTROL_OFFSET);
  assign active = !power_down && !soft_reset_busy;

  // Soft reset sequencer
  // self clearing reset
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      soft_reset_count <= 4'h0;
    end else if (hit && reg_wdata[SOFT_RESET_BIT]) begin
      soft_reset_count <= SOFT_RESET_CYCLES;
    end else if (soft_reset_count != 4'h0) begin
      soft_reset_count <= soft_reset_count - 4'h1;
    end
  end
  assign soft_reset_busy = (soft_reset_count != 4'h0);

  // Plain control bits
  // reset value
  always_ff @(posedge clock) begin
    if (!reset_n || soft_reset_busy) begin
      loopback       <= BASIC_MODE_CONTROL_RESET[LOOPBACK_BIT];
      speed_sel      <= BASIC_MODE_CONTROL_RESET[SPEED_BIT];
      autoneg_en_bit <= BASIC_MODE_CONTROL_RESET[AUTONEG_EN_BIT];
      isolate        <= BASIC_MODE_CONTROL_RESET[ISOLATE_BIT];
      duplex_sel     <= BASIC_MODE_CONTROL_RESET[DUPLEX_BIT];
      col_test       <= BASIC_MODE_CONTROL_RESET[COL_TEST_BIT];
    end else if (hit) begin
      loopback       <= reg_wdata[LOOPBACK_BIT];
      speed_sel      <= reg_wdata[SPEED_BIT];
      autoneg_en_bit <= reg_wdata[AUTONEG_EN_BIT];
      isolate        <= reg_wdata[ISOLATE_BIT];
      duplex_sel     <= reg_wdata[DUPLEX_BIT];
      col_test       <= reg_wdata[COL_TEST_BIT];
    end
  end

  // Power-down bit, pin sets it
  // pin sets bit
  always_ff @(posedge clock) begin
    if (!reset_n || soft_reset_busy) begin
      power_down_bit <= BASIC_MODE_CONTROL_RESET[POWER_DOWN_BIT];
    end else if (!irq_powerdown_pin_n) begin
      power_down_bit <= 1'b1;
    end else if (hit) begin
      power_down_bit <= reg_wdata[POWER_DOWN_BIT];
    end
  end
  assign power_down = power_down_bit || !irq_powerdown_pin_n;

  // Restart request tracking
  // restart handling
  always_ff @(posedge clock) begin
    if (!reset_n || soft_reset_busy) begin
      restart_state <= PBMC_IDLE;
    end else begin
      unique case (restart_state)
        PBMC_IDLE: begin
          if (hit && reg_wdata[AUTONEG_RST_BIT] && autoneg_en_bit) begin
            restart_state <= PBMC_PENDING;
          end
        end
        PBMC_PENDING: begin
          if (autoneg_started || !autoneg_en_bit) begin
            restart_state <= PBMC_IDLE;
          end
        end
        default: restart_state <= PBMC_IDLE;
      endcase
    end
  end
  assign autoneg_restart = (restart_state == PBMC_PENDING) && active;

  // Readback; reserved low bits zero
  // reserved zero
  assign control_word = {soft_reset_busy, loopback, speed_sel, autoneg_en_bit, power_down,
                         isolate, (restart_state == PBMC_PENDING), duplex_sel, col_test, 7'h00};
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      reg_rdata <= 16'h0000;
    end else begin
      reg_rdata <= (reg_addr == BASIC_MODE_CONTROL_OFFSET) ?
                   (control_word & WRITE_MASK) : 16'h0000;
    end
  end

  // Operating speed and duplex
  // mode selection
  assign autoneg_enable = autoneg_en_bit && active;
  assign speed_100      = autoneg_en_bit ? speed_100_negotiated : speed_sel;
  assign full_duplex    = autoneg_en_bit ? full_duplex_negotiated : duplex_sel;

  // Reference clock gating
  // clock stops
  assign ref_clock_out  = ref_clock_in && rmii_master_mode && !isolate && active;
  assign ref_clock_oe_n = !(rmii_master_mode && !isolate && active);

  // Datapath: loopback, isolation, power-down
  // datapath steering
  always_ff @(posedge clock) begin
    if (!reset_n || !active || isolate) begin
      mac_crs_dv <= 1'b0;
      mac_rxd    <= 2'h0;
      line_tx_en <= 1'b0;
      line_txd   <= 2'h0;
    end else if (loopback) begin
      mac_crs_dv <= mac_tx_en;
      mac_rxd    <= mac_txd;
      line_tx_en <= 1'b0;
      line_txd   <= 2'h0;
    end else begin
      mac_crs_dv <= line_crs_dv;
      mac_rxd    <= line_rxd;
      line_tx_en <= mac_tx_en;
      line_txd   <= mac_txd;
    end
  end

  // Collision test, one cycle after TX_EN each way
  // collision test
  always_ff @(posedge clock) begin
    if (!reset_n || !active || isolate) begin
      mac_col <= 1'b0;
    end else begin
      mac_col <= col_test && mac_tx_en;
    end
  end

  // Assertions
  property p_col_on;
    @(posedge clock) disable iff (!reset_n)
      (col_test && active && !isolate && mac_tx_en && !soft_reset_busy) ##1
      (col_test && active && !isolate) |-> mac_col;
  endproperty
  a_col_on: assert property (p_col_on) else $error("col not asserted");

  property p_col_off;
    @(posedge clock) disable iff (!reset_n) !mac_tx_en |=> !mac_col;
  endproperty
  a_col_off: assert property (p_col_off) else $error("col not released");

  property p_pin_sets;
    @(posedge clock) disable iff (!reset_n)
      (!irq_powerdown_pin_n && !soft_reset_busy) |=> power_down_bit;
  endproperty
  a_pin_sets: assert property (p_pin_sets) else $error("pin did not set power down");

  property p_restart_ignored;
    @(posedge clock) disable iff (!reset_n)
      (hit && !autoneg_en_bit && restart_state == PBMC_IDLE && !soft_reset_busy) |=>
      restart_state == PBMC_IDLE;
  endproperty
  a_restart_ignored: assert property (p_restart_ignored) else $error("restart not ignored");

  property p_restart_hold;
    @(posedge clock) disable iff (!reset_n)
      (restart_state == PBMC_PENDING && !autoneg_started && autoneg_en_bit && !soft_reset_busy)
      |=> restart_state == PBMC_PENDING;
  endproperty
  a_restart_hold: assert property (p_restart_hold) else $error("restart cleared early");

  property p_forced_speed;
    @(posedge clock) disable iff (!reset_n)
      !autoneg_en_bit |-> (speed_100 == speed_sel) && (full_duplex == duplex_sel);
  endproperty
  a_forced_speed: assert property (p_forced_speed) else $error("forced mode wrong");

  property p_isolate_clock;
    @(posedge clock) disable iff (!reset_n) isolate |-> ref_clock_oe_n && !ref_clock_out;
  endproperty
  a_isolate_clock: assert property (p_isolate_clock) else $error("clock driven in isolate");

  property p_isolate_data;
    @(posedge clock) disable iff (!reset_n) $past(isolate) |-> !mac_crs_dv && !line_tx_en;
  endproperty
  a_isolate_data: assert property (p_isolate_data) else $error("data passed in isolate");

  property p_reserved;
    @(posedge clock) disable iff (!reset_n) reg_rdata[6:0] == 7'h00;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits nonzero");

  property p_neg_mode;
    @(posedge clock) disable iff (!reset_n)
      autoneg_en_bit |->
      (speed_100 == speed_100_negotiated) && (full_duplex == full_duplex_negotiated);
  endproperty
  a_neg_mode: assert property (p_neg_mode) else $error("neg mode wrong");

  property p_down_ctrl;
    @(posedge clock) disable iff (!reset_n)
      power_down |-> !autoneg_enable && !autoneg_restart && ref_clock_oe_n;
  endproperty
  a_down_ctrl: assert property (p_down_ctrl) else $error("active while down");

  property p_down_data;
    @(posedge clock) disable iff (!reset_n)
      $past(power_down) |-> !mac_crs_dv && !line_tx_en && !mac_col;
  endproperty
  a_down_data: assert property (p_down_data) else $error("data while down");

  property p_restart_done;
    @(posedge clock) disable iff (!reset_n)
      (restart_state == PBMC_PENDING && autoneg_started) |=> restart_state == PBMC_IDLE;
  endproperty
  a_restart_done: assert property (p_restart_done) else $error("restart stuck");

  property p_zero_keeps;
    @(posedge clock) disable iff (!reset_n)
      (restart_state == PBMC_PENDING && hit && !reg_wdata[AUTONEG_RST_BIT] && autoneg_en_bit &&
       !autoneg_started && !soft_reset_busy) |=> restart_state == PBMC_PENDING;
  endproperty
  a_zero_keeps: assert property (p_zero_keeps) else $error("restart dropped");

  property p_soft_values;
    @(posedge clock) disable iff (!reset_n)
      soft_reset_busy |=>
      ({loopback, speed_sel, autoneg_en_bit, power_down_bit, isolate} ==
       BASIC_MODE_CONTROL_RESET[LOOPBACK_BIT:ISOLATE_BIT]) &&
      (duplex_sel == BASIC_MODE_CONTROL_RESET[DUPLEX_BIT]) && (restart_state == PBMC_IDLE);
  endproperty
  a_soft_values: assert property (p_soft_values) else $error("soft reset wrong");

  property p_soft_end;
    @(posedge clock) disable iff (!reset_n)
      (soft_reset_count == 4'h1 && !(hit && reg_wdata[SOFT_RESET_BIT])) |=> !soft_reset_busy;
  endproperty
  a_soft_end: assert property (p_soft_end) else $error("soft reset stuck");

  property p_loopback;
    @(posedge clock) disable iff (!reset_n)
      (loopback && active && !isolate) |=>
      (mac_rxd == $past(mac_txd)) && (mac_crs_dv == $past(mac_tx_en)) && !line_tx_en;
  endproperty
  a_loopback: assert property (p_loopback) else $error("loopback wrong");

  c_loopback: cover property (@(posedge clock) loopback && mac_tx_en ##1 mac_crs_dv);
  c_col: cover property (@(posedge clock) col_test && mac_tx_en ##1 mac_col);
  c_restart: cover property (@(posedge clock) restart_state == PBMC_PENDING ##1 autoneg_started);
  c_soft: cover property (@(posedge clock) soft_reset_busy ##1 !soft_reset_busy);
  c_down: cover property (@(posedge clock) !irq_powerdown_pin_n ##1 power_down_bit);

endmodule

// ==== pbmc_far_end.sv ====
`timescale 1ns/1ns
module pbmc_far_end
  import pbmc_pkg::*;
#(
  parameter int START_DELAY = 6
) (
  input  wire logic       clock,
  input  wire logic       autoneg_restart,
  output logic            autoneg_started,
  output logic            speed_100_negotiated,
  output logic            full_duplex_negotiated,
  input  wire logic       line_tx_en,
  input  wire logic [1:0] line_txd,
  output logic            line_crs_dv,
  output logic [1:0]      line_rxd
);
  int wait_count;
  // Negotiated result differs from the register defaults on purpose
  assign speed_100_negotiated   = 1'b0;
  assign full_duplex_negotiated = 1'b0;
  initial begin
    wait_count      = 0;
    autoneg_started = 1'b0;
    line_crs_dv     = 1'b0;
    line_rxd        = 2'h0;
  end
  // Engine starts a while after a restart request
  always @(posedge clock) begin
    wait_count      <= autoneg_restart ? wait_count + 1 : 0;
    autoneg_started <= autoneg_restart && (wait_count >= START_DELAY);
  end
  // Remote line loop; idle data toggles so stale values never pass
  always @(posedge clock) begin
    line_crs_dv <= line_tx_en;
    line_rxd    <= line_tx_en ? line_txd : ~line_rxd;
  end
endmodule

// ==== phy_basic_mode_control_tb.sv ====
`timescale 1ns/1ns
module phy_basic_mode_control_tb;
  import pbmc_pkg::*;
  logic        clock, reset_n, reg_write, irq_powerdown_pin_n, autoneg_restart;
  logic        autoneg_started, autoneg_enable, speed_100, speed_100_negotiated;
  logic        full_duplex, full_duplex_negotiated, power_down, soft_reset_busy;
  logic        rmii_master_mode, ref_clock_in, ref_clock_out, ref_clock_oe_n;
  logic        mac_tx_en, mac_crs_dv, mac_col, line_tx_en, line_crs_dv;
  logic [1:0]  mac_txd, mac_rxd, line_txd, line_rxd, prev;
  logic [4:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, model;
  int          err_count, tests_run, cycles, seed;

  pbmc_basic_control u_pbmc_basic_control (.clock, .reset_n, .reg_write, .reg_addr,
    .reg_wdata, .reg_rdata, .irq_powerdown_pin_n, .autoneg_restart, .autoneg_started,
    .autoneg_enable, .speed_100, .speed_100_negotiated, .full_duplex,
    .full_duplex_negotiated, .power_down, .soft_reset_busy, .rmii_master_mode,
    .ref_clock_in, .ref_clock_out, .ref_clock_oe_n, .mac_tx_en, .mac_txd, .mac_crs_dv,
    .mac_rxd, .mac_col, .line_tx_en, .line_txd, .line_crs_dv, .line_rxd);
  pbmc_far_end #(.START_DELAY(10)) u_pbmc_far_end (.clock, .autoneg_restart,
    .autoneg_started, .speed_100_negotiated, .full_duplex_negotiated, .line_tx_en,
    .line_txd, .line_crs_dv, .line_rxd);

  // Clock, 50 ns period
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // Hang guard
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      summarize();
    end
  end

  task automatic summarize;
    $display("Checks %0d, errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Register write, model follows the stored-bit behaviour
  task automatic wr(input logic [15:0] d);
    logic [15:0] m;
    @(negedge clock);
    reg_write = 1'b1;
    reg_wdata = d;
    @(negedge clock);
    reg_write = 1'b0;
    m = d & 16'h7f80;
    // Restart takes only with bit 12 already stored; a written 0 keeps it pending
    m[9] = m[12] && model[12] && (d[9] || model[9]);
    model = d[15] ? BASIC_MODE_CONTROL_RESET : m;
  endtask
  task automatic rd(input string what);
    repeat (2) @(negedge clock);
    chk(what, reg_rdata, model | (irq_powerdown_pin_n ? 16'h0000 : 16'h0800));
  endtask

  initial begin
    {err_count, tests_run, cycles} = '0;
    seed = 24855;
    {reset_n, reg_write, mac_tx_en, mac_txd, reg_addr, reg_wdata} = '0;
    {irq_powerdown_pin_n, rmii_master_mode, ref_clock_in} = 3'b111;
    model = BASIC_MODE_CONTROL_RESET;
    repeat (8) @(negedge clock);
    reset_n = 1'b1;
    rd("reset word");
    chk("negotiated speed", 16'(speed_100), 16'h0000);
    chk("negotiated duplex", 16'(full_duplex), 16'h0000);
    chk("aneg enable", 16'(autoneg_enable), 16'h0001);
    wr(16'h007f);
    rd("reserved bits");
    chk("manual speed 10", 16'(speed_100), 16'h0000);
    chk("manual half", 16'(full_duplex), 16'h0000);
    wr(16'h2100);
    chk("manual speed 100", 16'(speed_100), 16'h0001);
    chk("manual full", 16'(full_duplex), 16'h0001);
    wr(16'h0200);
    rd("restart ignored");
    chk("no restart", 16'(autoneg_restart), 16'h0000);
    wr(16'h1000);
    wr(16'h1200);
    rd("restart pending");
    wr(16'h1000);
    rd("restart kept");
    chk("restart out", 16'(autoneg_restart), 16'h0001);
    repeat (20) @(negedge clock);
    model[9] = 1'b0;
    rd("restart cleared");
    reg_addr = 5'(1 + ($unsigned($random(seed)) % 31));
    repeat (2) @(negedge clock);
    chk("unmapped", reg_rdata, 16'h0000);
    reg_addr = BASIC_MODE_CONTROL_OFFSET;
    // self-test speed setup is software's, in a register outside this block
    wr(16'h4000);
    for (int i = 0; i < 8; i++) begin
      @(negedge clock);
      if (i > 0) begin
        chk("loop rx", 16'({mac_crs_dv, mac_rxd}), 16'({1'b1, prev}));
        chk("loop line idle", 16'(line_tx_en), 16'h0000);
      end
      prev = 2'($random(seed));
      mac_txd = prev;
      mac_tx_en = 1'b1;
    end
    // Normal path through the far end, three registers deep
    wr(16'h0000);
    repeat (4) @(negedge clock);
    chk("line rxd", 16'(mac_rxd), 16'(mac_txd));
    chk("ref clock on", 16'({ref_clock_out, ref_clock_oe_n}), 16'h0002);
    rmii_master_mode = 1'b0;
    @(negedge clock);
    chk("slave ref clock", 16'({ref_clock_out, ref_clock_oe_n}), 16'h0001);
    rmii_master_mode = 1'b1;
    wr(16'h0400);
    repeat (2) @(negedge clock);
    chk("isolated rxd", 16'({mac_crs_dv, mac_rxd}), 16'h0000);
    chk("ref clock off", 16'({ref_clock_out, ref_clock_oe_n}), 16'h0001);
    mac_tx_en = 1'b0;
    wr(16'h0080);
    mac_tx_en = 1'b1;
    @(negedge clock);
    chk("col raise", 16'(mac_col), 16'h0001);
    mac_tx_en = 1'b0;
    repeat (2) @(negedge clock);
    chk("col drop", 16'(mac_col), 16'h0000);
    wr(16'h0000);
    irq_powerdown_pin_n = 1'b0;
    mac_tx_en = 1'b1;
    rd("pin power down");
    chk("power down", 16'(power_down), 16'h0001);
    chk("down rx", 16'({mac_crs_dv, mac_rxd}), 16'h0000);
    irq_powerdown_pin_n = 1'b1;
    model[11] = 1'b1;
    rd("power down held");
    wr(16'h8000);
    chk("soft busy", 16'(soft_reset_busy), 16'h0001);
    repeat (10) @(negedge clock);
    rd("after soft reset");
    // Second reset in mid-run
    wr(16'h4400);
    reset_n = 1'b0;
    repeat (2) @(negedge clock);
    reset_n = 1'b1;
    model = BASIC_MODE_CONTROL_RESET;
    rd("reset again");
    summarize();
  end
endmodule
